// file: hw/hbfp_top.sv
// Top of the half-bridge fault protection controller
`timescale 1ns/100ps
`default_nettype none

`include "hbfp_map.svh"

module hbfp_top #(
    parameter logic [13:0] EN_MIN_CYC  = 14'((`HBFP_EN_PULSE_MIN_NS + `HBFP_CLK_PERIOD_NS - 1) / `HBFP_CLK_PERIOD_NS),
    parameter logic [13:0] EN_MAX_CYC  = 14'(`HBFP_EN_PULSE_MAX_NS / `HBFP_CLK_PERIOD_NS),
    parameter logic [13:0] FCLR_CYC    = 14'((`HBFP_FAULT_CLEAR_NS + `HBFP_CLK_PERIOD_NS - 1) / `HBFP_CLK_PERIOD_NS)
) (
    input  wire logic                 sys_clk,
    input  wire logic                 rst_b,
    input  wire logic                 enable,
    input  wire logic                 brake,
    input  wire hbfp_pkg::hbfp_phase_t high_side_cmd,
    input  wire hbfp_pkg::hbfp_phase_t low_side_cmd,
    input  wire hbfp_pkg::hbfp_fet_t  fet_overcurrent_trip,
    input  wire logic                 over_temperature_shutdown,
    input  wire logic                 gate_supply_undervoltage,
    input  wire hbfp_pkg::hbfp_phase_t bootstrap_low_flag,
    input  wire hbfp_pkg::hbfp_phase_t phase_current_limit,
    input  wire logic                 current_limit_reference_low,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output var  logic [31:0]          reg_rdata,
    output var  logic                 irq,
    output var  hbfp_pkg::hbfp_phase_t high_side_drive,
    output var  hbfp_pkg::hbfp_phase_t low_side_drive,
    output var  logic                 fault_out_n_o,
    output var  logic                 fault_out_n_oe_n
);

    localparam logic [7:0] BLANK_CYC = 8'(`HBFP_BLANK_CYC);

    // ------------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------------
    logic [22:0]           pins_s;
    logic                  en_s;
    logic                  brake_s;
    hbfp_pkg::hbfp_phase_t hs_s;
    hbfp_pkg::hbfp_phase_t ls_s;
    hbfp_pkg::hbfp_fet_t   oc_s;
    logic                  ot_s;
    logic                  uv_s;
    hbfp_pkg::hbfp_phase_t boot_s;
    hbfp_pkg::hbfp_phase_t cmp_s;
    logic                  ref_low_s;

    hbfp_sync #(.W(23)) u_sync (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .async_in ({enable, brake, high_side_cmd, low_side_cmd, fet_overcurrent_trip,
                    over_temperature_shutdown, gate_supply_undervoltage, bootstrap_low_flag,
                    phase_current_limit, current_limit_reference_low}),
        .sync_out (pins_s)
    );

    assign {en_s, brake_s, hs_s, ls_s, oc_s, ot_s, uv_s, boot_s, cmp_s, ref_low_s} = pins_s;

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    logic [`HBFP_EV_W-1:0] status_q;
    logic [`HBFP_EV_W-1:0] mask_q;
    logic [7:0]            ctrl_q;

    // ------------------------------------------------------------------------
    // Enable low pulse measurement
    // ------------------------------------------------------------------------
    hbfp_pkg::hbfp_en_state_t en_state_q;
    hbfp_pkg::hbfp_count_t    en_cnt_q;
    logic                     en_clear_q;

    // Counter saturates one past the maximum so a long sleep never clears
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            en_state_q <= hbfp_pkg::HBFP_EN_HIGH;
            en_cnt_q   <= '0;
            en_clear_q <= 1'b0;
        end else begin
            en_clear_q <= 1'b0;
            unique case (en_state_q)
                hbfp_pkg::HBFP_EN_HIGH: begin
                    en_cnt_q <= '0;
                    if (!en_s) begin
                        en_state_q <= hbfp_pkg::HBFP_EN_LOW;
                        en_cnt_q   <= 14'h0001;
                    end
                end
                hbfp_pkg::HBFP_EN_LOW: begin
                    if (en_s) begin
                        en_state_q <= hbfp_pkg::HBFP_EN_HIGH;
                        en_clear_q <= (en_cnt_q >= EN_MIN_CYC) && (en_cnt_q <= EN_MAX_CYC);
                    end else if (en_cnt_q <= EN_MAX_CYC) begin
                        en_cnt_q <= en_cnt_q + 14'h0001;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Latched faults
    // ------------------------------------------------------------------------
    logic oc_latch_q;
    logic ot_latch_q;
    logic uv_prev_q;
    logic supply_cycle;

    // Falling undervoltage marks a completed supply cycle
    assign supply_cycle = uv_prev_q && !uv_s;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            uv_prev_q <= 1'b0;
        end else begin
            uv_prev_q <= uv_s;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            oc_latch_q <= 1'b0;
        end else if (|oc_s) begin
            oc_latch_q <= 1'b1;
        end else if (en_clear_q || supply_cycle) begin
            oc_latch_q <= 1'b0;
        end
    end

    // A live trip holds the latch, so clearing takes effect only once cool
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ot_latch_q <= 1'b0;
        end else if (ot_s) begin
            ot_latch_q <= 1'b1;
        end else if (en_clear_q || supply_cycle) begin
            ot_latch_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Current limit: blanking, per-phase qualifier, fault clear timer
    // ------------------------------------------------------------------------
    hbfp_pkg::hbfp_phase_t hs_prev_q;
    hbfp_pkg::hbfp_phase_t ls_prev_q;
    logic [7:0]            blank_q;
    logic                  cmd_edge;
    hbfp_pkg::hbfp_phase_t cl_trip;
    hbfp_pkg::hbfp_phase_t hs_block;
    hbfp_pkg::hbfp_count_t fclr_q;
    logic                  cl_off;
    logic                  cl_enabled;

    assign cmd_edge   = |{hs_s ^ hs_prev_q, ls_s ^ ls_prev_q};
    assign cl_enabled = ref_low_s && ctrl_q[`HBFP_CTRL_CL_ALLOW];
    assign cl_off     = fclr_q != 14'h0000;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            hs_prev_q <= '0;
            ls_prev_q <= '0;
            blank_q   <= '0;
        end else begin
            hs_prev_q <= hs_s;
            ls_prev_q <= ls_s;
            if (cmd_edge) begin
                blank_q <= BLANK_CYC;
            end else if (blank_q != 8'h00) begin
                blank_q <= blank_q - 8'h01;
            end
        end
    end

    for (genvar p = 0; p < 3; p++) begin : g_phase
        hbfp_phase u_phase (
            .sys_clk  (sys_clk),
            .rst_b    (rst_b),
            .blank    (cmd_edge || (blank_q != 8'h00)),
            .cmp_high (cmp_s[p]),
            .hs_cmd   (hs_s[p]),
            .boot_low (boot_s[p]),
            .cl_trip  (cl_trip[p]),
            .hs_block (hs_block[p])
        );
    end

    // A new trip during the off period restarts the full clear time
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            fclr_q <= '0;
        end else if (cl_enabled && (|cl_trip)) begin
            fclr_q <= FCLR_CYC;
        end else if (cl_off) begin
            fclr_q <= fclr_q - 14'h0001;
        end
    end

    // ------------------------------------------------------------------------
    // Gate drive
    // ------------------------------------------------------------------------
    logic fault_any;
    logic all_off;

    assign fault_any = oc_latch_q || ot_latch_q || uv_s || cl_off;
    assign all_off   = !en_s || fault_any;

    // Both commands high is treated as off, guarding against shoot-through
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            high_side_drive <= '0;
            low_side_drive  <= '0;
        end else if (all_off) begin
            high_side_drive <= '0;
            low_side_drive  <= '0;
        end else if (brake_s) begin
            high_side_drive <= '0;
            low_side_drive  <= '1;
        end else begin
            high_side_drive <= hs_s & ~ls_s & ~hs_block;
            low_side_drive  <= ls_s & ~hs_s;
        end
    end

    // Open drain: output value stays low, enable low pulls the pin
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            fault_out_n_o    <= 1'b0;
            fault_out_n_oe_n <= 1'b1;
        end else begin
            fault_out_n_o    <= 1'b0;
            fault_out_n_oe_n <= !fault_any;
        end
    end

    // ------------------------------------------------------------------------
    // Status, mask and interrupt
    // ------------------------------------------------------------------------
    logic [`HBFP_EV_W-1:0] events;
    logic [`HBFP_EV_W-1:0] w1c;

    always_comb begin
        events                       = '0;
        events[`HBFP_EV_OVERCURRENT] = oc_latch_q;
        events[`HBFP_EV_OVERTEMP]    = ot_latch_q;
        events[`HBFP_EV_SUPPLY_UV]   = uv_s;
        events[`HBFP_EV_CUR_LIMIT]   = cl_off;
        events[`HBFP_EV_BOOT_UV]     = |boot_s;
    end

    assign w1c = (reg_wr && reg_addr == `HBFP_ADDR_STATUS) ? reg_wdata[`HBFP_EV_W-1:0] : '0;

    // A set in the same cycle as a clear wins
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            status_q <= '0;
        end else begin
            status_q <= (status_q & ~w1c) | events;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mask_q <= `HBFP_MASK_RST;
            ctrl_q <= `HBFP_CTRL_RST;
        end else if (reg_wr && reg_addr == `HBFP_ADDR_MASK) begin
            mask_q <= reg_wdata[`HBFP_EV_W-1:0];
        end else if (reg_wr && reg_addr == `HBFP_ADDR_CTRL) begin
            ctrl_q <= reg_wdata[7:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((status_q & ~w1c) | events) & mask_q);
        end
    end

    // ------------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `HBFP_ADDR_STATUS: reg_rdata <= {27'h0000000, status_q};
                `HBFP_ADDR_MASK:   reg_rdata <= {27'h0000000, mask_q};
                `HBFP_ADDR_STATE:  reg_rdata <= {22'h000000, en_s, hs_block, cl_off, uv_s,
                                                 ot_latch_q, oc_latch_q, fault_any, brake_s};
                `HBFP_ADDR_CTRL:   reg_rdata <= {24'h000000, ctrl_q};
                default:           reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

endmodule : hbfp_top

`default_nettype wire

// file: hw/hbfp_map.svh
// Constants of the half-bridge fault protection block: register offsets, fields, resets and timing
`ifndef HBFP_MAP_SVH
`define HBFP_MAP_SVH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define HBFP_CLK_PERIOD_NS     5
`define HBFP_EN_PULSE_MIN_NS   20000
`define HBFP_EN_PULSE_MAX_NS   40000
`define HBFP_FAULT_CLEAR_NS    50000
`define HBFP_BLANK_NS          500
`define HBFP_DEGLITCH_NS       200
`define HBFP_BLANK_CYC    ((`HBFP_BLANK_NS + `HBFP_CLK_PERIOD_NS - 1) / `HBFP_CLK_PERIOD_NS)
`define HBFP_DEGLITCH_CYC ((`HBFP_DEGLITCH_NS + `HBFP_CLK_PERIOD_NS - 1) / `HBFP_CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define HBFP_ADDR_STATUS  8'h00
`define HBFP_ADDR_MASK    8'h04
`define HBFP_ADDR_STATE   8'h08
`define HBFP_ADDR_CTRL    8'h0c

// ----------------------------------------------------------------------------
// Status and mask bit positions
// ----------------------------------------------------------------------------
`define HBFP_EV_OVERCURRENT  0
`define HBFP_EV_OVERTEMP     1
`define HBFP_EV_SUPPLY_UV    2
`define HBFP_EV_CUR_LIMIT    3
`define HBFP_EV_BOOT_UV      4
`define HBFP_EV_W            5

// ----------------------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------------------
`define HBFP_CTRL_CL_ALLOW   0
`define HBFP_CTRL_RST        8'h01
`define HBFP_MASK_RST        5'h00

`endif

// file: hw/hbfp_pkg.sv
// Types of the half-bridge fault protection block
`default_nettype none

package hbfp_pkg;

    typedef logic [2:0] hbfp_phase_t;
    typedef logic [5:0] hbfp_fet_t;
    typedef logic [13:0] hbfp_count_t;

    typedef enum logic {
        HBFP_EN_HIGH,
        HBFP_EN_LOW
    } hbfp_en_state_t;

endpackage : hbfp_pkg

`default_nettype wire

// file: hw/hbfp_sync.sv
// Two-flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/100ps
`default_nettype none

module hbfp_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] async_in,
    output var  logic [W-1:0] sync_out
);

    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : hbfp_sync

`default_nettype wire

// file: hw/hbfp_phase.sv
// Per-phase current-limit qualifier and bootstrap lockout
`timescale 1ns/100ps
`default_nettype none

`include "hbfp_map.svh"

module hbfp_phase (
    input  wire logic sys_clk,
    input  wire logic rst_b,
    input  wire logic blank,
    input  wire logic cmp_high,
    input  wire logic hs_cmd,
    input  wire logic boot_low,
    output var  logic cl_trip,
    output var  logic hs_block
);

    localparam logic [7:0] DEGL_CYC = 8'(`HBFP_DEGLITCH_CYC);

    logic [7:0] degl_q;
    logic       hs_prev_q;

    // ------------------------------------------------------------------------
    // Deglitch of the comparator rising edge
    // ------------------------------------------------------------------------
    // Blanking restarts the count, so a trip needs a full quiet-window high
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            degl_q  <= '0;
            cl_trip <= 1'b0;
        end else if (!cmp_high || blank) begin
            degl_q  <= '0;
            cl_trip <= 1'b0;
        end else if (degl_q < DEGL_CYC) begin
            degl_q  <= degl_q + 8'h01;
            cl_trip <= (degl_q + 8'h01) == DEGL_CYC;
        end
    end

    // ------------------------------------------------------------------------
    // Bootstrap lockout
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            hs_prev_q <= 1'b0;
            hs_block  <= 1'b0;
        end else begin
            hs_prev_q <= hs_cmd;
            if (boot_low) begin
                hs_block <= 1'b1;
            end else if (hs_cmd && !hs_prev_q) begin
                hs_block <= 1'b0;
            end
        end
    end

endmodule : hbfp_phase

`default_nettype wire

// file: verification/hbfp_pwm_model.sv
// Stand-in for the motor-control PWM controller that drives the phase commands
`timescale 1ns/100ps
`default_nettype none

module hbfp_pwm_model (
    input  wire logic                  sys_clk,
    input  wire logic                  rst_b,
    input  wire hbfp_pkg::hbfp_phase_t hs_pattern,
    input  wire hbfp_pkg::hbfp_phase_t ls_pattern,
    output var  hbfp_pkg::hbfp_phase_t high_side_cmd,
    output var  hbfp_pkg::hbfp_phase_t low_side_cmd
);
    // ------------------------------------------------------------------
    // Timer compare outputs
    // ------------------------------------------------------------------
    // Commands only move just after an edge, as a PWM timer output would
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            high_side_cmd <= 3'h0;
            low_side_cmd  <= 3'h0;
        end else begin
            high_side_cmd <= hs_pattern;
            low_side_cmd  <= ls_pattern;
        end
    end
endmodule : hbfp_pwm_model
`default_nettype wire

// file: verification/hbfp_top_asserts.sv
// Port-level assertions for the half-bridge fault protection top
`timescale 1ns/100ps
`default_nettype none

module hbfp_top_asserts (
    input wire logic                  sys_clk,
    input wire logic                  rst_b,
    input wire logic                  enable,
    input wire logic                  brake,
    input wire hbfp_pkg::hbfp_fet_t   fet_overcurrent_trip,
    input wire logic                  over_temperature_shutdown,
    input wire logic                  gate_supply_undervoltage,
    input wire hbfp_pkg::hbfp_phase_t bootstrap_low_flag,
    input wire logic                  reg_rd,
    input wire logic [31:0]           reg_rdata,
    input wire hbfp_pkg::hbfp_phase_t high_side_drive,
    input wire hbfp_pkg::hbfp_phase_t low_side_drive,
    input wire logic                  fault_out_n_oe_n
);
    // ------------------------------------------------------------------
    // Pins show at the drive registers three edges after they change, latched faults four
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_brake_live;
        $past(enable, 3) && $past(brake, 3) && fault_out_n_oe_n;
    endsequence

    en_low_off_a: assert property (!$past(enable, 3) |-> {high_side_drive, low_side_drive} == 6'h00)
        else $error("drive on while enable low");
    oc_trip_off_a: assert property (|$past(fet_overcurrent_trip, 4) |->
        {high_side_drive, low_side_drive, fault_out_n_oe_n} == 7'h00)
        else $error("overcurrent trip did not stop the bridge");
    ot_trip_off_a: assert property ($past(over_temperature_shutdown, 4) |->
        {high_side_drive, low_side_drive, fault_out_n_oe_n} == 7'h00)
        else $error("thermal trip did not stop the bridge");
    uv_trip_off_a: assert property ($past(gate_supply_undervoltage, 3) |->
        {high_side_drive, low_side_drive, fault_out_n_oe_n} == 7'h00)
        else $error("supply undervoltage did not stop the bridge");
    // One edge more here: the lockout flop sits ahead of the drive flop
    boot_hs_off_a: assert property ((high_side_drive & $past(bootstrap_low_flag, 4)) == 3'h0)
        else $error("high side on under bootstrap undervoltage");
    brake_low_on_a: assert property (s_brake_live |-> low_side_drive == 3'h7 && high_side_drive == 3'h0)
        else $error("brake pattern wrong");
    fault_drive_off_a: assert property (!fault_out_n_oe_n |-> {high_side_drive, low_side_drive} == 6'h00)
        else $error("drive on while fault reported");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside read cycle");
    phase_excl_a: assert property ((high_side_drive & low_side_drive) == 3'h0)
        else $error("both switches of a phase on");
endmodule : hbfp_top_asserts

bind hbfp_top hbfp_top_asserts u_asserts (
    .sys_clk                  (sys_clk),
    .rst_b                    (rst_b),
    .enable                   (enable),
    .brake                    (brake),
    .fet_overcurrent_trip     (fet_overcurrent_trip),
    .over_temperature_shutdown(over_temperature_shutdown),
    .gate_supply_undervoltage (gate_supply_undervoltage),
    .bootstrap_low_flag       (bootstrap_low_flag),
    .reg_rd                   (reg_rd),
    .reg_rdata                (reg_rdata),
    .high_side_drive          (high_side_drive),
    .low_side_drive           (low_side_drive),
    .fault_out_n_oe_n         (fault_out_n_oe_n)
);
`default_nettype wire

// file: verification/hbfp_bench.sv
// Self-checking bench for the half-bridge fault protection top
`timescale 1ns/100ps
`default_nettype none

`include "hbfp_map.svh"

module hbfp_bench;
    // Short counts keep the run brief; every expectation uses these values
    localparam logic [13:0] EN_MIN = 14'h000a;
    localparam logic [13:0] EN_MAX = 14'h0014;
    localparam logic [13:0] FCLR   = 14'h001e;
    logic                  sys_clk, rst_b, enable, brake, ot, uv, cl_ref_low, reg_wr, reg_rd, irq, fo, oe_n;
    hbfp_pkg::hbfp_phase_t hs_pat, ls_pat, hs_cmd, ls_cmd, boot_low, cl_cmp, hs_drv, ls_drv;
    hbfp_pkg::hbfp_fet_t   oc_trip;
    logic [7:0]            reg_addr;
    logic [31:0]           reg_wdata, reg_rdata;
    int                    num_errors = 0;
    int                    num_checks = 0;

    always #2.5 sys_clk = ~sys_clk;

    hbfp_pwm_model u_pwm (.sys_clk(sys_clk), .rst_b(rst_b), .hs_pattern(hs_pat), .ls_pattern(ls_pat),
        .high_side_cmd(hs_cmd), .low_side_cmd(ls_cmd));

    hbfp_top #(.EN_MIN_CYC(EN_MIN), .EN_MAX_CYC(EN_MAX), .FCLR_CYC(FCLR)) u_dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .enable(enable), .brake(brake),
        .high_side_cmd(hs_cmd), .low_side_cmd(ls_cmd), .fet_overcurrent_trip(oc_trip),
        .over_temperature_shutdown(ot), .gate_supply_undervoltage(uv), .bootstrap_low_flag(boot_low),
        .phase_current_limit(cl_cmp), .current_limit_reference_low(cl_ref_low),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq), .high_side_drive(hs_drv), .low_side_drive(ls_drv),
        .fault_out_n_o(fo), .fault_out_n_oe_n(oe_n));

    // ------------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------------
    task automatic report_and_stop();
        if (num_errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Sampled at the falling edge so the rising edge's updates have landed
    task automatic drv(input logic [2:0] hs, input logic [2:0] ls, input logic oe, input logic ir);
        @(negedge sys_clk);
        check("drive hs ls oe_n irq fault_o", {23'h0, hs, ls, oe, ir, 1'b0}, {23'h0, hs_drv, ls_drv, oe_n, irq, fo});
        @(posedge sys_clk);
    endtask : drv

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        @(negedge sys_clk);
        check("read data", exp, reg_rdata);
        @(posedge sys_clk);
    endtask : rd

    task automatic en_pulse(input int n);
        enable <= 1'b0;
        tick(n);
        enable <= 1'b1;
        tick(10);
    endtask : en_pulse

    task automatic cl_burst(input int n);
        cl_cmp <= 3'b010;
        tick(n);
        cl_cmp <= 3'h0;
        tick(6);
    endtask : cl_burst

    task automatic wait_oe(input logic want, input int limit);
        int n = 0;
        // Look only once the edge's updates have landed
        @(negedge sys_clk);
        while (oe_n !== want && n < limit) begin
            @(negedge sys_clk);
            n++;
        end
        if (oe_n !== want) begin
            num_errors++;
            $display("CHECK FAILED fault pin wait expected %h seen %h", want, oe_n);
            report_and_stop();
        end
        @(posedge sys_clk);
    endtask : wait_oe

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        rst_b = 1'b0;
        {enable, brake, ot, uv, reg_wr, reg_rd} = 6'h00;
        cl_ref_low = 1'b1;
        {hs_pat, ls_pat, boot_low, cl_cmp} = 12'h000;
        oc_trip = 6'h00;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        tick(2);
        rst_b <= 1'b1;
        rd(`HBFP_ADDR_CTRL, 32'h1);
        rd(`HBFP_ADDR_MASK, 32'h0);
        rd(`HBFP_ADDR_STATUS, 32'h0);
        rd(8'h10, 32'h0);
        hs_pat <= 3'b101;
        ls_pat <= 3'b110;
        brake <= 1'b1;
        tick(6);
        drv(3'h0, 3'h0, 1'b1, 1'b0);
        enable <= 1'b1;
        tick(6);
        drv(3'h0, 3'h7, 1'b1, 1'b0);
        brake <= 1'b0;
        tick(6);
        drv(3'b001, 3'b010, 1'b1, 1'b0);
        boot_low <= 3'b001;
        tick(6);
        drv(3'h0, 3'b010, 1'b1, 1'b0);
        boot_low <= 3'h0;
        tick(6);
        drv(3'h0, 3'b010, 1'b1, 1'b0);
        hs_pat <= 3'b100;
        tick(6);
        hs_pat <= 3'b101;
        tick(6);
        drv(3'b001, 3'b010, 1'b1, 1'b0);
        wr(`HBFP_ADDR_MASK, 32'h1);
        uv <= 1'b1;
        tick(6);
        drv(3'h0, 3'h0, 1'b0, 1'b0);
        uv <= 1'b0;
        tick(6);
        drv(3'b001, 3'b010, 1'b1, 1'b0);
        wr(`HBFP_ADDR_STATUS, 32'h1f);
        for (int i = 0; i < 6; i++) begin
            oc_trip[i] <= 1'b1;
            tick(1);
            oc_trip <= 6'h00;
            tick(30);
            drv(3'h0, 3'h0, 1'b0, 1'b1);
            if (i == 0) begin
                rd(`HBFP_ADDR_STATUS, 32'h1);
                rd(`HBFP_ADDR_STATE, 32'h206);
                en_pulse(int'(EN_MIN) - 1);
                drv(3'h0, 3'h0, 1'b0, 1'b1);
                en_pulse(int'(EN_MAX) + 1);
                drv(3'h0, 3'h0, 1'b0, 1'b1);
            end
            en_pulse(i[0] ? int'(EN_MAX) : int'(EN_MIN));
            drv(3'b001, 3'b010, 1'b1, 1'b1);
            wr(`HBFP_ADDR_STATUS, 32'h1f);
            tick(2);
        end
        rd(`HBFP_ADDR_STATUS, 32'h0);
        ot <= 1'b1;
        tick(6);
        drv(3'h0, 3'h0, 1'b0, 1'b0);
        en_pulse(15);
        drv(3'h0, 3'h0, 1'b0, 1'b0);
        ot <= 1'b0;
        tick(6);
        drv(3'h0, 3'h0, 1'b0, 1'b0);
        en_pulse(15);
        drv(3'b001, 3'b010, 1'b1, 1'b0);
        // Comparator bursts shorter than the deglitch, or with the limit disabled or blanked, must not stop the bridge
        cl_burst(30);
        drv(3'b001, 3'b010, 1'b1, 1'b0);
        wr(`HBFP_ADDR_CTRL, 32'h0);
        cl_burst(60);
        drv(3'b001, 3'b010, 1'b1, 1'b0);
        wr(`HBFP_ADDR_CTRL, 32'h1);
        cl_ref_low <= 1'b0;
        cl_burst(60);
        drv(3'b001, 3'b010, 1'b1, 1'b0);
        cl_ref_low <= 1'b1;
        hs_pat <= 3'b100;
        tick(2);
        cl_burst(60);
        drv(3'h0, 3'b010, 1'b1, 1'b0);
        hs_pat <= 3'b101;
        tick(110);
        cl_cmp <= 3'b001;
        wait_oe(1'b0, 60);
        cl_cmp <= 3'h0;
        drv(3'h0, 3'h0, 1'b0, 1'b0);
        tick(int'(FCLR) - 12);
        drv(3'h0, 3'h0, 1'b0, 1'b0);
        wait_oe(1'b1, 20);
        drv(3'b001, 3'b010, 1'b1, 1'b0);
        report_and_stop();
    end
endmodule : hbfp_bench
`default_nettype wire
